// ### hdl/cmc_map.vh
`ifndef CMC_MAP_VH
`define CMC_MAP_VH
// Function
// RULE_01: Output is four times input, scaled by 1, 2/3, 1/2, 2/5, 1/3 or 2/7; here select 00 ignores scaling and always uses 1.
// RULE_02: Input is external oscillator, or internal/external halved; three base outputs; here select 10 also gives the internal oscillator direct, times four.
// RULE_03: Software first writes zero to the whole control register.
// RULE_04: Software picks input select, then scaling, before enabling.
// RULE_05: Top bit enables the multiplier, other fields kept; zero disables.
// RULE_06: Software waits over five microseconds, then sets init with enable.
// RULE_07: Init bit reads zero; writing one while enabled starts initialization; here ignored until wait_ff reaches WAIT_CYC after enable.
// RULE_08: Read-only ready flag is one once locked, zero otherwise.
// RULE_09: Software polls ready until one before using the output.
// RULE_10: External oscillator must be stable before initialization is written.
// RULE_11: Slow input gives four fast pulses per period, then idles.
// RULE_12: Software aims for an output between 25 and 50 MHz.
// RULE_13: Enable bit 7, init 6, ready 5, scaling 4:2, select 1:0; reset zero.
// RULE_14: Select 11 is external times four; 00, 01 are times two.
// RULE_15: Output duty cycle need not be half for some scalings.
// RULE_16: Clearing enable stops the multiplier and drops ready until re-initialized.
// RULE_17: Ready writes ignored; select and scaling apply only at initialization.

// Register location and layout
`define CMC_CTRL_ADDR     8'h97
`define CMC_CTRL_RESET    8'h00
`define CMC_EN_BIT        7
`define CMC_INIT_BIT      6
`define CMC_RDY_BIT       5
`define CMC_DIV_HI        4
`define CMC_DIV_LO        2
`define CMC_SEL_HI        1
`define CMC_SEL_LO        0

// Timing
`define CMC_CLK_PERIOD_NS 50
`define CMC_EN_WAIT_NS    5000
`define CMC_EN_WAIT_CYC   ((`CMC_EN_WAIT_NS / `CMC_CLK_PERIOD_NS) + 1)

// Output edges per raw input period before scaling
`define CMC_TOG_X2        5'h08
`define CMC_TOG_X4        5'h10
`define CMC_BURST_TOG     4'h8
`endif

// ### hdl/cmc_osc_meter.v
`timescale 1ns/1ps
module cmc_osc_meter #(
	parameter PER_W = 16
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Oscillator pin
	input  wire             osc_in,
	// Measurement
	output reg              rise,
	output reg  [PER_W-1:0] period,
	output reg              stale
);
	reg             s1_ff;
	reg             s2_ff;
	reg             s3_ff;
	reg             lvl_ff;
	reg [PER_W-1:0] cnt_ff;

	wire             nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
	wire             edge_up = nxt_lvl & ~lvl_ff;
	wire [PER_W-1:0] cnt_max = {PER_W{1'b1}};

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_ff  <= 1'b0;
			s2_ff  <= 1'b0;
			s3_ff  <= 1'b0;
			lvl_ff <= 1'b0;
			cnt_ff <= {PER_W{1'b0}};
			rise   <= 1'b0;
			period <= {PER_W{1'b0}};
			stale  <= 1'b1;
		end
		else
		begin
			s1_ff  <= osc_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
			rise   <= edge_up;
			if (edge_up)
			begin
				period <= cnt_ff;
				cnt_ff <= {{(PER_W-1){1'b0}}, 1'b1};
				stale  <= (cnt_ff == cnt_max);
			end
			else if (cnt_ff != cnt_max)
				cnt_ff <= cnt_ff + {{(PER_W-1){1'b0}}, 1'b1};
			else
				stale <= 1'b1;
		end
	end
endmodule // cmc_osc_meter

// ### hdl/cmc_top.v
`timescale 1ns/1ps
`include "cmc_map.vh"
module cmc_top #(
	parameter             PER_W    = 16,
	parameter [15:0]      LOCK_TOL = 16'h0002,
	// Slowest input period, in clocks, the accumulator still synthesizes; slower inputs get bursts
	parameter [15:0]      SLOW_PER = 16'h0FA0
) (
	// Clock and reset
	input  wire           CLK,
	input  wire           SYS_RST,
	// Oscillator sources
	input  wire           INT_OSC,
	input  wire           EXT_OSC,
	// Special-function register port
	input  wire [7:0]     REG_ADDR,
	input  wire           REG_WR,
	input  wire [7:0]     REG_WDATA,
	input  wire           REG_RD,
	output reg  [7:0]     REG_RDATA,
	// Multiplier output
	output reg            MUL_CLK,
	output reg            MUL_READY
);
	localparam ACC_W     = PER_W + 4;
	localparam ST_IDLE   = 3'h0;
	localparam ST_ARMED  = 3'h1;
	localparam ST_MEAS1  = 3'h2;
	localparam ST_MEAS2  = 3'h3;
	localparam ST_LOCK   = 3'h4;
	localparam [31:0] WAIT_FULL = `CMC_EN_WAIT_CYC;
	localparam [7:0]  WAIT_CYC  = WAIT_FULL[7:0];
	localparam [7:0]  CTRL_RST  = `CMC_CTRL_RESET;

	// Control fields
	reg             en_ff;
	reg [1:0]       sel_ff;
	reg [2:0]       div_ff;
	// Settings captured at initialization
	reg [1:0]       act_sel_ff;
	reg [2:0]       act_div_ff;
	reg [2:0]       state_ff;
	reg [2:0]       nxt_state;
	reg [7:0]       wait_ff;
	reg [PER_W-1:0] ref_ff;
	reg [PER_W-1:0] nxt_ref;
	reg [ACC_W-1:0] acc_ff;
	reg [ACC_W-1:0] nxt_acc;
	reg [3:0]       burst_ff;
	reg [3:0]       nxt_burst;
	reg             nxt_clk;

	wire             int_rise;
	wire             ext_rise;
	wire [PER_W-1:0] int_per;
	wire [PER_W-1:0] ext_per;
	wire             int_stale;
	wire             ext_stale;

	// Distance between two period samples
	function [PER_W-1:0] per_diff;
		input [PER_W-1:0] a;
		input [PER_W-1:0] b;
		begin
			per_diff = (a > b) ? (a - b) : (b - a);
		end
	endfunction

	// Scaling denominator 2..7; times-two internal ignores scaling
	function [2:0] scale_den;
		input [1:0] sel;
		input [2:0] div;
		begin
			if (sel == 2'b00 || div > 3'h5)
				scale_den = 3'h2;
			else
				scale_den = div + 3'h2;
		end
	endfunction

	cmc_osc_meter #(
		.PER_W  (PER_W)
	) u_int_meter (
		.clk    (CLK),
		.rst    (SYS_RST),
		.osc_in (INT_OSC),
		.rise   (int_rise),
		.period (int_per),
		.stale  (int_stale)
	);

	cmc_osc_meter #(
		.PER_W  (PER_W)
	) u_ext_meter (
		.clk    (CLK),
		.rst    (SYS_RST),
		.osc_in (EXT_OSC),
		.rise   (ext_rise),
		.period (ext_per),
		.stale  (ext_stale)
	);

	// Odd select codes take the external oscillator
	wire             src_ext   = act_sel_ff[0]; // see RULE_02
	wire             src_rise  = src_ext ? ext_rise : int_rise;
	wire [PER_W-1:0] src_per   = src_ext ? ext_per : int_per;
	wire             src_stale = src_ext ? ext_stale : int_stale;

	wire ctrl_wr  = REG_WR && (REG_ADDR == `CMC_CTRL_ADDR);
	wire wait_ok  = (wait_ff == WAIT_CYC);
	// Init is honoured only with enable already set and kept
	wire init_go  = ctrl_wr && en_ff && wait_ok && REG_WDATA[`CMC_EN_BIT]
		&& REG_WDATA[`CMC_INIT_BIT]; // see RULE_07
	wire in_tol   = per_diff(src_per, ref_ff) <= LOCK_TOL[PER_W-1:0];

	// Edges per raw input period: halved input gives x2, direct x4
	wire [4:0]       tog_num = act_sel_ff[1] ? `CMC_TOG_X4 : `CMC_TOG_X2; // see RULE_14
	wire [2:0]       den     = scale_den(act_sel_ff, act_div_ff); // see RULE_01
	wire [ACC_W-1:0] lim     = {{(ACC_W-3){1'b0}}, den} * {4'h0, ref_ff};
	wire [ACC_W-1:0] acc_add = acc_ff + {{(ACC_W-5){1'b0}}, tog_num};
	wire             slow    = ref_ff > SLOW_PER[PER_W-1:0];

	// Register writes
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			en_ff  <= CTRL_RST[`CMC_EN_BIT]; // see RULE_13
			sel_ff <= CTRL_RST[`CMC_SEL_HI:`CMC_SEL_LO];
			div_ff <= CTRL_RST[`CMC_DIV_HI:`CMC_DIV_LO];
		end
		else if (ctrl_wr)
		begin
			// Ready bit is never stored from a write
			en_ff  <= REG_WDATA[`CMC_EN_BIT]; // see RULE_05
			sel_ff <= REG_WDATA[`CMC_SEL_HI:`CMC_SEL_LO]; // see RULE_17
			div_ff <= REG_WDATA[`CMC_DIV_HI:`CMC_DIV_LO];
		end
	end

	// Enable settle counter
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			wait_ff <= 8'h00;
		else if (!en_ff)
			wait_ff <= 8'h00;
		else if (!wait_ok)
			wait_ff <= wait_ff + 8'h01;
	end

	// Lock state machine
	always @*
	begin
		nxt_state = state_ff;
		nxt_ref   = ref_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (en_ff)
					nxt_state = ST_ARMED;
			end
			ST_ARMED:
			begin
				if (init_go)
					nxt_state = ST_MEAS1;
			end
			ST_MEAS1:
			begin
				if (src_rise)
				begin
					nxt_ref   = src_per;
					nxt_state = ST_MEAS2;
				end
			end
			ST_MEAS2:
			begin
				// Two matching periods in a row count as lock
				if (src_rise)
				begin
					nxt_ref = src_per;
					if (in_tol && !src_stale)
						nxt_state = ST_LOCK; // see RULE_08
				end
			end
			ST_LOCK:
			begin
				// Drift or a stopped source loses lock
				if (src_stale || (src_rise && !in_tol))
					nxt_state = ST_MEAS2;
			end
			default:
				nxt_state = ST_IDLE;
		endcase
		if (init_go)
			nxt_state = ST_MEAS1;
		if (!en_ff)
			nxt_state = ST_IDLE; // see RULE_16
	end

	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			state_ff   <= ST_IDLE;
			ref_ff     <= {PER_W{1'b0}};
			act_sel_ff <= 2'h0;
			act_div_ff <= 3'h0;
			MUL_READY  <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			ref_ff    <= nxt_ref;
			MUL_READY <= (nxt_state == ST_LOCK); // see RULE_08
			if (init_go)
			begin
				// New settings only take hold here
				act_sel_ff <= REG_WDATA[`CMC_SEL_HI:`CMC_SEL_LO]; // see RULE_17
				act_div_ff <= REG_WDATA[`CMC_DIV_HI:`CMC_DIV_LO];
			end
		end
	end

	// Output synthesis: fractional accumulator, or bursts for slow inputs
	always @*
	begin
		nxt_acc   = acc_ff;
		nxt_burst = burst_ff;
		nxt_clk   = MUL_CLK;
		if (state_ff != ST_LOCK)
		begin
			nxt_acc   = {ACC_W{1'b0}};
			nxt_burst = 4'h0;
			nxt_clk   = 1'b0; // see RULE_16
		end
		else if (slow)
		begin
			// Four fast pulses, then quiet until the next rising edge
			if (src_rise)
			begin
				nxt_burst = `CMC_BURST_TOG - 4'h1; // see RULE_11
				nxt_clk   = 1'b1;
			end
			else if (burst_ff != 4'h0)
			begin
				nxt_burst = burst_ff - 4'h1;
				nxt_clk   = ~MUL_CLK;
			end
			else
				nxt_clk = 1'b0;
		end
		else if (acc_add >= lim)
		begin
			// Uneven spacing of edges; duty cycle is only approximate
			nxt_acc = acc_add - lim; // see RULE_15
			nxt_clk = ~MUL_CLK; // see RULE_01
		end
		else
			nxt_acc = acc_add;
	end

	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			acc_ff   <= {ACC_W{1'b0}};
			burst_ff <= 4'h0;
			MUL_CLK  <= 1'b0;
		end
		else
		begin
			acc_ff   <= nxt_acc;
			burst_ff <= nxt_burst;
			MUL_CLK  <= nxt_clk;
		end
	end

	// Register read; init always reads zero
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			REG_RDATA <= 8'h00;
		else if (REG_RD && (REG_ADDR == `CMC_CTRL_ADDR))
			REG_RDATA <= {en_ff, 1'b0, MUL_READY, div_ff, sel_ff}; // see RULE_13
		else
			REG_RDATA <= 8'h00;
	end
endmodule // cmc_top

// ### verif/clock_multiplier_control_tb_top.sv
`timescale 1ns/1ps
module clock_multiplier_control_tb_top;
	logic       CLK;
	logic       SYS_RST;
	wire        INT_OSC;
	wire        EXT_OSC;
	logic [7:0] REG_ADDR;
	logic       REG_WR;
	logic [7:0] REG_WDATA;
	logic       REG_RD;
	wire  [7:0] REG_RDATA;
	wire        MUL_CLK;
	wire        MUL_READY;
	int         num_errors;
	int         checked;
	int         cycles;
	integer     seed;
	logic [7:0] cfg;
	logic [7:0] adr;
	logic [31:0] rnd;
	cmc_top #(.SLOW_PER(16'h00C8)) u_cmc_top (.CLK(CLK), .SYS_RST(SYS_RST), .INT_OSC(INT_OSC),
		.EXT_OSC(EXT_OSC), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MUL_CLK(MUL_CLK), .MUL_READY(MUL_READY));
	cmc_osc_model u_cmc_osc_model (.int_osc(INT_OSC), .ext_osc(EXT_OSC));
	initial
	begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		#2 {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
		@(posedge CLK);
		#2 REG_WR = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge CLK);
		#2 {REG_ADDR, REG_RD} = {a, 1'b1};
		@(posedge CLK);
		#2 REG_RD = 1'b0;
		chk(REG_RDATA & m, e);
	endtask
	// Toggles per n raw source periods
	function automatic int exp_tog(input logic [1:0] s, input logic [2:0] dv, input int n);
		int den;
		den = (s == 2'b00 || dv > 3'd5) ? 2 : dv + 2;
		return n * (s[1] ? 16 : 8) / den;
	endfunction
	task automatic run_cfg(input logic [1:0] s, input logic [2:0] dv, input int n, input int p);
		int tog;
		int e;
		logic prv;
		cfg = {3'b000, dv, s};
		wr(8'h97, 8'h00);
		wr(8'h97, {6'h00, s});
		wr(8'h97, cfg);
		wr(8'h97, cfg | 8'h80);
		wr(8'h97, cfg | 8'hC0);
		// Early init must stay ignored; 95 cycles spans two 40-clock internal periods, not the slower sources
		repeat (95) @(posedge CLK);
		#2 chk(MUL_READY, 16'h0000);
		repeat (15) @(posedge CLK);
		wr(8'h97, cfg | 8'hC0);
		tog = 0;
		while (MUL_READY !== 1'b1 && tog < 3000)
		begin
			@(posedge CLK);
			#2 tog++;
		end
		rd(8'h97, 8'hE0, 8'hA0);
		// Field edits while locked must not retune the output
		wr(8'h97, 8'h80 | (cfg ^ 8'h1C));
		rd(8'h97, 8'h1F, (cfg ^ 8'h1C) & 8'h1F);
		tog = 0;
		prv = MUL_CLK;
		repeat (n * p)
		begin
			@(posedge CLK);
			#2 tog += (MUL_CLK !== prv);
			prv = MUL_CLK;
		end
		e = exp_tog(s, dv, n);
		// Window edges cut at most one period of toggles
		chk((tog > e ? tog - e : e - tog) <= 8, 16'h0001);
		wr(8'h97, 8'h00);
		rd(8'h97, 8'hFF, 8'h00);
		$display("config select %0d scale %0d done", s, dv);
	endtask
	initial
	begin
		{REG_ADDR, REG_WDATA, REG_WR, REG_RD} = 18'h00000;
		{num_errors, checked, cycles} = 0;
		seed = 32'h9CC8;
		SYS_RST = 1'b1;
		repeat (6) @(posedge CLK);
		#2 SYS_RST = 1'b0;
		rd(8'h97, 8'hFF, 8'h00);
		repeat (8)
		begin
			rnd = $random(seed);
			cfg = rnd[7:0];
			adr = rnd[15:8];
			if (adr == 8'h97)
				adr = 8'h00;
			wr(adr, ~cfg);
			wr(8'h97, cfg);
			rd(8'h97, 8'hFF, cfg & 8'h9F);
			rd(adr, 8'hFF, 8'h00);
		end
		$display("register access done");
		for (int i = 0; i < 8; i++)
			run_cfg(i[1:0], i[2:0], 105, i[0] ? 60 : 40);
		u_cmc_osc_model.int_half = 10000;
		repeat (800) @(posedge CLK);
		run_cfg(2'b10, 3'd0, 10, 400);
		complete_run();
	end
endmodule // clock_multiplier_control_tb_top

// ### verif/cmc_osc_model.sv
`timescale 1ns/1ps
module cmc_osc_model (
	// Oscillator pins
	output logic int_osc,
	output logic ext_osc
);
	// Half periods in ns, retimed by the bench; far below a real target, ratios matter
	int int_half = 1000;
	int ext_half = 1500;
	initial
	begin
		int_osc = 1'b0;
		forever #(int_half) int_osc = ~int_osc;
	end
	// Free running from time zero, so stable long before any init write
	initial
	begin
		ext_osc = 1'b0;
		#7;
		forever #(ext_half) ext_osc = ~ext_osc;
	end
endmodule // cmc_osc_model

// ### verif/cmc_top_chk.sv
`timescale 1ns/1ps
module cmc_top_chk (
	// Clock and reset
	input wire       CLK,
	input wire       SYS_RST,
	// Register port
	input wire [7:0] REG_ADDR,
	input wire       REG_WR,
	input wire [7:0] REG_WDATA,
	input wire       REG_RD,
	input wire [7:0] REG_RDATA,
	// Multiplier output
	input wire       MUL_CLK,
	input wire       MUL_READY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	wire rd_hit = REG_RD && REG_ADDR == 8'h97;
	wire wr_hit = REG_WR && REG_ADDR == 8'h97;
	property p_rd_idle; !rd_hit |=> REG_RDATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_init_rd0; rd_hit |=> !REG_RDATA[6]; endproperty
	a_init_rd0: assert property (p_init_rd0) else $error("init bit read as one");
	property p_rdy_bit; rd_hit |=> REG_RDATA[5] == $past(MUL_READY); endproperty
	a_rdy_bit: assert property (p_rdy_bit) else $error("ready bit differs from flag");
	property p_clk_low; !MUL_READY [*3] |-> !MUL_CLK; endproperty
	a_clk_low: assert property (p_clk_low) else $error("output runs unlocked");
	property p_tog_rdy; $rose(MUL_CLK) |-> $past(MUL_READY); endproperty
	a_tog_rdy: assert property (p_tog_rdy) else $error("toggle without lock");
	// A forced fall trails a lost lock by one cycle
	property p_fall_rdy;
		$fell(MUL_CLK) |-> $past(MUL_READY) || $past(MUL_READY, 2);
	endproperty
	a_fall_rdy: assert property (p_fall_rdy) else $error("fall without recent lock");
	property p_dis; wr_hit && !REG_WDATA[7] |-> ##2 !MUL_READY [*8]; endproperty
	a_dis: assert property (p_dis) else $error("ready kept after disable");
	property p_wr_rd;
		wr_hit ##1 !wr_hit ##1 rd_hit |=> REG_RDATA[4:0] == $past(REG_WDATA[4:0], 3)
			&& REG_RDATA[7] == $past(REG_WDATA[7], 3);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("fields not kept");
	property p_wr_zero;
		(wr_hit && REG_WDATA == 8'h00) ##1 !wr_hit ##1 rd_hit |=> REG_RDATA == 8'h00;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("zero write not clean");
endmodule // cmc_top_chk
bind cmc_top cmc_top_chk u_cmc_top_chk (.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.MUL_CLK(MUL_CLK), .MUL_READY(MUL_READY));
